// ===== rtl/asf_pkg.sv
// Purpose: Shared constants for the ALU status flag block
// Assumes: 8-bit ALU, AHB-Lite register access with 32-bit data
// Notes: Register offsets are byte addresses
package asf_pkg;
   // ==========================================
   // Register map
   localparam logic [7:0] ASF_FLAGS_OFS = 8'h00;
   localparam logic [7:0] ASF_CTRL_OFS = 8'h04;
   localparam logic [7:0] ASF_OPER_OFS = 8'h08;
   localparam logic [7:0] ASF_RES_OFS = 8'h0C;
   // ==========================================
   // Flag bit positions
   localparam int ASF_C_BIT = 0;
   localparam int ASF_NIBBLE_CARRY_BIT = 1;
   localparam int ASF_Z_BIT = 2;
   localparam int ASF_SIGNED_WRAP_BIT = 3;
   localparam int ASF_N_BIT = 4;
   localparam logic [7:0] ASF_FLAG_MASK = 8'h1F;
   localparam logic [7:0] ASF_CTRL_RESET = 8'h00;
   localparam logic [31:0] ASF_ZERO_WORD = 32'h0000_0000;
   // ==========================================
   // Operations
   typedef enum logic [3:0] {
      ASF_OP_NONE,
      ASF_OP_ADD_REG_TO_W,
      ASF_OP_ADD_LITERAL_TO_W,
      ASF_OP_SUB_W_FROM_REG,
      ASF_OP_SUB_W_FROM_LITERAL,
      ASF_OP_AND,
      ASF_OP_ROTATE_RIGHT,
      ASF_OP_ROTATE_LEFT,
      ASF_OP_ZERO_REG,
      ASF_OP_BIT_CLEAR,
      ASF_OP_BIT_SET,
      ASF_OP_NIBBLE_EXCHANGE,
      ASF_OP_W_TO_REG_MOVE,
      ASF_OP_REG_TO_REG_MOVE
   } asf_op_t;
   typedef enum logic [2:0] {
      ASF_AM_INHERENT,
      ASF_AM_LITERAL,
      ASF_AM_DIRECT,
      ASF_AM_INDIRECT,
      ASF_AM_INDEXED_LIT
   } asf_amode_t;
endpackage

// ===== rtl/asf_alu.sv
// Purpose: Combinational 8-bit ALU with flag outputs
// Assumes: Operands are stable for the whole cycle
// Notes: Subtraction adds the two's complement of the subtrahend
`timescale 1ns/100ps
module asf_alu
   import asf_pkg::*;
(
   input wire asf_op_t op_in,
   input wire logic [7:0] a_in,
   input wire logic [7:0] b_in,
   input wire logic [7:0] w_in,
   output logic [7:0] res_out,
   output logic [4:0] flags_out,
   output logic [4:0] upd_out
);
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] x;
   logic [7:0] y;
   always_comb begin
      x = a_in;
      y = w_in;
      if (op_in == ASF_OP_ADD_LITERAL_TO_W || op_in == ASF_OP_SUB_W_FROM_LITERAL) begin
         x = b_in;
      end
      if (op_in == ASF_OP_SUB_W_FROM_REG || op_in == ASF_OP_SUB_W_FROM_LITERAL) begin
         y = ~w_in;
      end
      sum = {1'b0, x} + {1'b0, y};
      nib = {1'b0, x[3:0]} + {1'b0, y[3:0]};
      if (op_in == ASF_OP_SUB_W_FROM_REG || op_in == ASF_OP_SUB_W_FROM_LITERAL) begin
         sum = sum + 9'h001;
         nib = nib + 5'h01;
      end
      res_out = sum[7:0];
      flags_out = 5'h00;
      upd_out = 5'h00;
      case (op_in)
         ASF_OP_ADD_REG_TO_W, ASF_OP_ADD_LITERAL_TO_W,
         ASF_OP_SUB_W_FROM_REG, ASF_OP_SUB_W_FROM_LITERAL: begin
            flags_out[ASF_C_BIT] = sum[8];
            flags_out[ASF_NIBBLE_CARRY_BIT] = nib[4];
            flags_out[ASF_SIGNED_WRAP_BIT] = (x[7] == y[7]) && (sum[7] != x[7]);
            upd_out = 5'h1F;
         end
         ASF_OP_AND: begin
            res_out = a_in & w_in;
            upd_out[ASF_Z_BIT] = 1'b1;
            upd_out[ASF_N_BIT] = 1'b1;
         end
         ASF_OP_ROTATE_RIGHT: begin
            res_out = {a_in[0], a_in[7:1]};
            flags_out[ASF_C_BIT] = a_in[0];
            flags_out[ASF_NIBBLE_CARRY_BIT] = a_in[4];
            upd_out[ASF_C_BIT] = 1'b1;
            upd_out[ASF_NIBBLE_CARRY_BIT] = 1'b1;
         end
         ASF_OP_ROTATE_LEFT: begin
            res_out = {a_in[6:0], a_in[7]};
            flags_out[ASF_C_BIT] = a_in[7];
            flags_out[ASF_NIBBLE_CARRY_BIT] = a_in[3];
            upd_out[ASF_C_BIT] = 1'b1;
            upd_out[ASF_NIBBLE_CARRY_BIT] = 1'b1;
         end
         ASF_OP_ZERO_REG: begin
            res_out = 8'h00;
            upd_out[ASF_Z_BIT] = 1'b1;
         end
         ASF_OP_BIT_CLEAR: res_out = a_in & ~b_in;
         ASF_OP_BIT_SET: res_out = a_in | b_in;
         ASF_OP_NIBBLE_EXCHANGE: res_out = {a_in[3:0], a_in[7:4]};
         ASF_OP_W_TO_REG_MOVE: res_out = w_in;
         ASF_OP_REG_TO_REG_MOVE: res_out = a_in;
         default: res_out = a_in;
      endcase
      if (upd_out[ASF_Z_BIT]) begin
         flags_out[ASF_Z_BIT] = (res_out == 8'h00);
      end
      if (upd_out[ASF_N_BIT]) begin
         flags_out[ASF_N_BIT] = res_out[7];
      end
   end
endmodule // asf_alu

// ===== rtl/asf_top.sv
// Purpose: Status flag register of an 8-bit core ALU, driven over AHB-Lite
// Assumes: Single word transfers, OKAY response only
// Notes: An operation issued by a write to OPER executes in the data phase
`timescale 1ns/100ps
module asf_top
   import asf_pkg::*;
(
   input wire logic CORE_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic HSEL_IN,
   input wire logic [7:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [31:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   output logic [7:0] FLAGS_OUT,
   output logic MODE_ERR_OUT
);
   // ==========================================
   // Bus address phase capture
   logic wr_r;
   logic rd_r;
   logic [7:0] addr_r;
   logic [7:0] status_r;
   logic [7:0] ctrl_r;
   logic [7:0] res_r;
   logic [31:0] rdata_r;
   logic [7:0] flags_pin_r;
   logic ready_r;
   logic resp_r;
   logic mode_err_r;
   logic [7:0] w_r;
   logic [1:0] rst_sync_r;
   logic rst_n;
   // ==========================================
   // Reset release
   // Pin asserts at once but releases on the clock, two flops deep
   always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];
   wire take = HSEL_IN && HREADY_IN && HTRANS_IN[1];
   always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         addr_r <= 8'h00;
      end else begin
         wr_r <= take && HWRITE_IN;
         rd_r <= take && !HWRITE_IN;
         addr_r <= HADDR_IN;
      end
   end
   // ==========================================
   // Operation decode from OPER write
   // OPER word: [3:0] op, [6:4] mode, [7] dest is flag reg, [15:8] literal/mask,
   // [23:16] register operand, [24] source is flag reg
   wire oper_wr = wr_r && (addr_r == ASF_OPER_OFS);
   asf_op_t op;
   asf_amode_t am;
   logic dst_flags;
   logic src_flags;
   logic ext_isa_en;
   logic mode_ok;
   logic [7:0] a_opnd;
   always_comb begin
      op = asf_op_t'(HWDATA_IN[3:0]);
      am = asf_amode_t'(HWDATA_IN[6:4]);
      dst_flags = HWDATA_IN[7];
      src_flags = HWDATA_IN[24];
      ext_isa_en = ctrl_r[0];
      a_opnd = src_flags ? status_r : HWDATA_IN[23:16];
      mode_ok = 1'b0;
      // Fixed mode per op; other byte ops choose direct, indirect or, only with ctrl_r[0] set, indexed
      case (op)
         ASF_OP_NONE: mode_ok = (am == ASF_AM_INHERENT);
         ASF_OP_ADD_LITERAL_TO_W, ASF_OP_SUB_W_FROM_LITERAL: mode_ok = (am == ASF_AM_LITERAL);
         ASF_OP_REG_TO_REG_MOVE: mode_ok = (am == ASF_AM_DIRECT);
         default: begin
            mode_ok = (am == ASF_AM_DIRECT) || (am == ASF_AM_INDIRECT)
               || ((am == ASF_AM_INDEXED_LIT) && ext_isa_en);
         end
      endcase
      if (op > ASF_OP_REG_TO_REG_MOVE) begin
         mode_ok = 1'b0;
      end
   end
   logic [7:0] alu_res;
   logic [4:0] alu_flags;
   logic [4:0] alu_upd;
   asf_alu u_alu (
      .op_in(op),
      .a_in(a_opnd),
      .b_in(HWDATA_IN[15:8]),
      .w_in(w_r),
      .res_out(alu_res),
      .flags_out(alu_flags),
      .upd_out(alu_upd)
   );
   wire exec = oper_wr && mode_ok;
   // ==========================================
   // Flag register
   logic [7:0] status_nxt;
   always_comb begin
      status_nxt = status_r;
      if (exec) begin
         if (dst_flags) begin
            // Result lands only in flag bits not updated by the op
            status_nxt = (alu_res & ~{3'b000, alu_upd}) & ASF_FLAG_MASK;
            status_nxt = status_nxt | ({3'b000, alu_flags & alu_upd});
            status_nxt = status_nxt | (status_r & ~ASF_FLAG_MASK);
            if (op == ASF_OP_ZERO_REG) begin
               status_nxt = status_r | 8'h04;
            end
         end else begin
            status_nxt = (status_r & ~{3'b000, alu_upd})
               | {3'b000, alu_flags & alu_upd};
         end
      end else if (wr_r && addr_r == ASF_FLAGS_OFS) begin
         status_nxt = HWDATA_IN[7:0];
      end
      status_nxt = status_nxt & ASF_FLAG_MASK;
   end
   // No reset on the flags: they stay unknown until first written
   always_ff @(posedge CORE_CLK_IN) begin
      status_r <= status_nxt;
   end
   // ==========================================
   // Working register, control and result
   always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= ASF_CTRL_RESET;
         res_r <= 8'h00;
         w_r <= 8'h00;
         mode_err_r <= 1'b0;
      end else begin
         if (wr_r && addr_r == ASF_CTRL_OFS) begin
            ctrl_r <= {7'h00, HWDATA_IN[0]};
            w_r <= HWDATA_IN[15:8];
         end
         if (oper_wr) begin
            mode_err_r <= !mode_ok;
         end
         if (exec) begin
            res_r <= alu_res;
            if (!dst_flags && op != ASF_OP_REG_TO_REG_MOVE) begin
               w_r <= alu_res;
            end
         end
      end
   end
   // ==========================================
   // Read data
   always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= ASF_ZERO_WORD;
      end else if (take && !HWRITE_IN) begin
         if (HADDR_IN == ASF_FLAGS_OFS) begin
            rdata_r <= {24'h000000, status_nxt};
         end else if (HADDR_IN == ASF_CTRL_OFS) begin
            rdata_r <= {16'h0000, w_r, ctrl_r};
         end else if (HADDR_IN == ASF_RES_OFS) begin
            rdata_r <= {23'h000000, mode_err_r, res_r};
         end else begin
            rdata_r <= ASF_ZERO_WORD;
         end
      end
   end
   // ==========================================
   // Output flops
   // Ready and response never vary, but still leave from flops
   always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         flags_pin_r <= 8'h00;
         ready_r <= 1'b1;
         resp_r <= 1'b0;
      end else begin
         flags_pin_r <= status_nxt;
         ready_r <= 1'b1;
         resp_r <= 1'b0;
      end
   end
   assign HRDATA_OUT = rdata_r;
   assign HREADYOUT_OUT = ready_r;
   assign HRESP_OUT = resp_r;
   assign FLAGS_OUT = flags_pin_r;
   assign MODE_ERR_OUT = mode_err_r;
   // ==========================================
   // Checks
   upper_zero_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
      FLAGS_OUT[7:5] == 3'b000) else $error("upper flag bits set");
   clr_sets_z_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
      exec && dst_flags && op == ASF_OP_ZERO_REG |=> status_r[ASF_Z_BIT]
      && status_r[1:0] == $past(status_r[1:0])) else $error("zero op flag wrong");
   blocked_wr_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
      exec && dst_flags && alu_upd == 5'h1F |=> status_r[4:0] == $past(alu_flags))
      else $error("flag write not blocked");
   zero_flag_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
      exec && alu_upd[ASF_Z_BIT] && op != ASF_OP_ZERO_REG
      |=> status_r[ASF_Z_BIT] == ($past(alu_res) == 8'h00)) else $error("zero flag");
   neg_flag_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
      exec && alu_upd[ASF_N_BIT] |=> status_r[ASF_N_BIT] == $past(alu_res[7]))
      else $error("negative flag");
   hold_flags_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
      exec && !dst_flags && alu_upd == 5'h00 |=> $stable(status_r))
      else $error("flags changed");
   rot_carry_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
      exec && op == ASF_OP_ROTATE_LEFT && !dst_flags |=> status_r[1:0]
      == {$past(a_opnd[3]), $past(a_opnd[7])}) else $error("rotate carry");
   idx_gate_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
      oper_wr && am == ASF_AM_INDEXED_LIT && !ctrl_r[0] |=> mode_err_r)
      else $error("indexed mode accepted");
   sub_borrow_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
      exec && !dst_flags && op == ASF_OP_SUB_W_FROM_REG
      |=> status_r[ASF_C_BIT] == ($past(a_opnd) >= $past(w_r))) else $error("borrow");
   add_wrap_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
      exec && !dst_flags && op == ASF_OP_ADD_REG_TO_W |=> status_r[ASF_SIGNED_WRAP_BIT]
      == ($past(a_opnd[7]) == $past(w_r[7]) && $past(alu_res[7]) != $past(a_opnd[7])))
      else $error("signed wrap flag");
   add_carry_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
      exec && !dst_flags && op == ASF_OP_ADD_REG_TO_W
      |=> status_r[ASF_C_BIT] == (({1'b0, $past(a_opnd)} + {1'b0, $past(w_r)}) >= 9'h100)
      && status_r[ASF_NIBBLE_CARRY_BIT]
      == (({1'b0, $past(a_opnd[3:0])} + {1'b0, $past(w_r[3:0])}) >= 5'h10))
      else $error("add carries");
   direct_wr_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
      wr_r && addr_r == ASF_FLAGS_OFS
      |=> status_r == ($past(HWDATA_IN[7:0]) & ASF_FLAG_MASK))
      else $error("direct flag write");
   refused_hold_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
      oper_wr && !mode_ok |=> $stable(status_r) && mode_err_r)
      else $error("refused op ran");
   lit_mode_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
      oper_wr && op == ASF_OP_ADD_LITERAL_TO_W && am != ASF_AM_LITERAL |=> mode_err_r)
      else $error("literal op mode");
   flag_pin_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
      exec && alu_upd == 5'h1F |=> FLAGS_OUT[4:0] == status_r[4:0])
      else $error("flag port");
endmodule // asf_top

// ===== test/asf_ahb_master.sv
// Purpose: AHB-Lite master standing in for the core's decoder side
// Assumes: One slave, single word transfers, hready from the slave
// Notes: Write data is inverted once released, so stale data never matches
`timescale 1ns/100ps
module asf_ahb_master (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic go_in,
   input wire logic wr_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_in,
   output logic done_out,
   output logic [31:0] rdata_out,
   output logic [7:0] haddr_out,
   output logic [1:0] htrans_out,
   output logic hwrite_out,
   output logic [31:0] hwdata_out
);
   logic [1:0] st_r;
   // ==========================================
   // Address phase, data phase, then hand back
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= 2'h0;
         done_out <= 1'b0;
         rdata_out <= 32'h0;
         haddr_out <= 8'h0;
         htrans_out <= 2'h0;
         hwrite_out <= 1'b0;
         hwdata_out <= 32'h0;
      end else if (st_r == 2'h0) begin
         if (!go_in) begin
            done_out <= 1'b0;
         end else if (!done_out) begin
            htrans_out <= 2'h2;
            haddr_out <= addr_in;
            hwrite_out <= wr_in;
            st_r <= 2'h1;
         end
      end else if (st_r == 2'h1) begin
         if (hready_in) begin
            htrans_out <= 2'h0;
            hwdata_out <= wdata_in;
            st_r <= 2'h2;
         end
      end else if (hready_in) begin
         rdata_out <= hrdata_in;
         hwdata_out <= ~hwdata_out;
         done_out <= 1'b1;
         st_r <= 2'h0;
      end
   end
endmodule // asf_ahb_master

// ===== test/tb_top.sv
// Purpose: Self-checking bench for the ALU status flag block
// Assumes: Zero wait-state slave, OPER layout as in the hand-over map
// Notes: Rotate rows mask to carry bits only; other flags there are open
`timescale 1ns/100ps
module tb_top
   import asf_pkg::*;
;
   typedef struct {
      logic [7:0] w;
      logic [31:0] oper;
      logic [4:0] m;
      logic [4:0] f;
      logic [7:0] res;
   } asf_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic go = 1'b0;
   logic wr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic done, hwrite, hreadyout, hresp, mode_err;
   logic [31:0] rdata, hwdata, hrdata;
   logic [7:0] haddr, flags;
   logic [1:0] htrans;
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   asf_row_t rows[7] = '{
      '{8'h7F, 32'h0000_0112, 5'h1F, 5'h1A, 8'h80},
      '{8'hF0, 32'h000F_0035, 5'h1F, 5'h0E, 8'h00},
      '{8'hFF, 32'h0001_0021, 5'h1F, 5'h07, 8'h00},
      '{8'h06, 32'h0000_0514, 5'h1F, 5'h10, 8'hFF},
      '{8'h01, 32'h0080_0023, 5'h1F, 5'h09, 8'h7F},
      '{8'h00, 32'h0018_0026, 5'h03, 5'h02, 8'h0C},
      '{8'h00, 32'h0098_0027, 5'h03, 5'h03, 8'h31}};
   always #12.5 clk = ~clk;
   asf_ahb_master mst (.clk_in(clk), .rst_n_in(rst_n), .go_in(go), .wr_in(wr),
      .addr_in(addr), .wdata_in(wdata), .hready_in(hreadyout), .hrdata_in(hrdata),
      .done_out(done), .rdata_out(rdata), .haddr_out(haddr), .htrans_out(htrans),
      .hwrite_out(hwrite), .hwdata_out(hwdata));
   asf_top uut (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .HSEL_IN(1'b1), .HADDR_IN(haddr),
      .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
      .HREADY_IN(hreadyout), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout),
      .HRESP_OUT(hresp), .FLAGS_OUT(flags), .MODE_ERR_OUT(mode_err));
   task give_verdict;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, mismatches);
         if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      begin
         comparisons++;
         if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   // ==========================================
   // One bus transfer; a stuck handshake is cut short
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      begin
         n = 0;
         @(posedge clk);
         go <= 1'b1;
         wr <= w;
         addr <= a;
         wdata <= d;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while (done !== 1'b1 && n < 20);
         if (n >= 20) chk("handshake", 32'h1, 32'h0);
         @(posedge clk);
         go <= 1'b0;
         @(posedge clk);
      end
   endtask
   // Loads W and extended enable, issues the op, reads flags back
   task op_chk(input logic [7:0] w, input logic x, input logic [31:0] op,
               input logic [4:0] m, input logic [4:0] f, input logic e);
      begin
         xfer(1'b1, ASF_CTRL_OFS, {16'h0, w, 7'h0, x});
         xfer(1'b1, ASF_OPER_OFS, op);
         xfer(1'b0, ASF_FLAGS_OFS, 32'h0);
         chk("flags", {24'h0, 3'h0, f}, {24'h0, rdata[7:0] & {3'h7, m}});
         chk("mode error", {31'h0, e}, {31'h0, mode_err});
      end
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         chk("timeout", 32'h1, 32'h0);
         give_verdict;
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      #1;
      chk("reset outputs", 32'h0000_0400, {21'h0, hreadyout, flags, mode_err, hresp});
      $display("test reset done");
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         op_chk(rows[i].w, 1'b0, rows[i].oper, rows[i].m, rows[i].f, 1'b0);
         chk("flag port", {27'h0, rows[i].f}, {27'h0, flags[4:0] & rows[i].m});
         xfer(1'b0, ASF_RES_OFS, 32'h0);
         chk("result", {23'h0, 1'b0, rows[i].res}, {23'h0, rdata[8:0]});
      end
      op_chk(8'h55, 1'b0, 32'h0000_002C, 5'h1F, 5'h0B, 1'b0);
      $display("test arithmetic rows done");
      op_chk(8'hFF, 1'b0, 32'h0000_00AC, 5'h1F, 5'h1F, 1'b0);
      chk("flag port top", 32'h0, {29'h0, flags[7:5]});
      op_chk(8'hFF, 1'b0, 32'h0100_04A9, 5'h1F, 5'h1B, 1'b0);
      op_chk(8'hFF, 1'b0, 32'h0000_00A8, 5'h1F, 5'h1F, 1'b0);
      op_chk(8'hFF, 1'b0, 32'h0100_00AB, 5'h1F, 5'h11, 1'b0);
      op_chk(8'hFF, 1'b0, 32'h0100_08AA, 5'h1F, 5'h19, 1'b0);
      op_chk(8'hFF, 1'b0, 32'h0002_00AD, 5'h1F, 5'h02, 1'b0);
      op_chk(8'h7F, 1'b0, 32'h0000_0192, 5'h1F, 5'h1A, 1'b0);
      $display("test flag register as target done");
      op_chk(8'hF0, 1'b0, 32'h000F_0045, 5'h1F, 5'h1A, 1'b1);
      xfer(1'b0, ASF_RES_OFS, 32'h0);
      chk("result error", 32'h1, {31'h0, rdata[8]});
      op_chk(8'hF0, 1'b1, 32'h000F_0045, 5'h14, 5'h04, 1'b0);
      op_chk(8'h01, 1'b0, 32'h0000_0122, 5'h14, 5'h04, 1'b1);
      $display("test addressing modes done");
      xfer(1'b0, ASF_CTRL_OFS, 32'h0);
      chk("control", 32'h0000_0100, rdata);
      xfer(1'b1, 8'h10, 32'hFFFF_FFFF);
      xfer(1'b0, 8'h10, 32'h0);
      chk("unmapped", ASF_ZERO_WORD, rdata);
      xfer(1'b0, ASF_FLAGS_OFS, 32'h0);
      chk("flags kept", 32'h0000_0004, rdata & 32'h0000_0014);
      xfer(1'b1, ASF_FLAGS_OFS, 32'hFFFF_FFEA);
      xfer(1'b0, ASF_FLAGS_OFS, 32'h0);
      chk("flags written", 32'h0000_000A, rdata);
      $display("test map done");
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("reset again", 32'h0000_0400, {21'h0, hreadyout, flags, mode_err, hresp});
      @(posedge clk);
      rst_n <= 1'b1;
      xfer(1'b0, ASF_FLAGS_OFS, 32'h0);
      chk("flags through reset", 32'h0000_000A, rdata);
      xfer(1'b0, ASF_CTRL_OFS, 32'h0);
      chk("control after reset", ASF_ZERO_WORD, rdata);
      $display("test reset again done");
      give_verdict;
   end
endmodule // tb_top
